// ### dsc_map.svh
// offsets, field positions and bit counts of the serial command decoder
// assumes: included by bare name from the lookup and decoder design modules
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH

// ==========================================
// command byte layout and frame lengths
`define DSC_POS_OP_LAST 5'h06
`define DSC_POS_CMD_LAST 5'h07
`define DSC_POS_DATA_FIRST 5'h08
`define DSC_POS_LONG_LAST 5'h17
`define DSC_CNT_ZERO 5'h00
`define DSC_CNT_STEP 5'h01

// ==========================================
// operation codes
`define DSC_OP_WRITE 2'h0
`define DSC_OP_READ 2'h3
`define DSC_OP_ENABLE 2'h2
`define DSC_OP_DISABLE 2'h1

// ==========================================
// reset values
`define DSC_SDO_IDLE 1'h1
`define DSC_WORD_ZERO 16'h0000

`endif

// ### dsc_pkg.sv
// types shared by the serial command decoder modules
// assumes: nothing beyond the constants header
package dsc_pkg;

  // ==========================================
  // link phase of the command in progress
  typedef enum logic [0:0]
  {
    DSC_ST_CMD = 1'b0,
    DSC_ST_DATA = 1'b1
  } dsc_state_t;

  // ==========================================
  // kind of event handed to the system clock side
  typedef enum logic [1:0]
  {
    DSC_EV_WR_VOL = 2'b00,
    DSC_EV_WR_NV = 2'b01,
    DSC_EV_CFG_EN = 2'b10,
    DSC_EV_CFG_DIS = 2'b11
  } dsc_event_t;

endpackage

// ### dsc_sync.sv
// two-flop synchroniser for levels and toggles
// assumes: i_d is stable for several destination clocks per change
`timescale 1ns/1ps
module dsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb
  begin
    next_meta = i_d;
    next_q = meta;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta <= RST_VAL;
      o_q <= RST_VAL;
    end
    else
    begin
      meta <= next_meta;
      o_q <= next_q;
    end
  end
endmodule

// ### dsc_cmd_lut.sv
// legal address/operation lookup and nonvolatile location map
// assumes: purely combinational, driven from the link clock domain
`timescale 1ns/1ps
`include "dsc_map.svh"
module dsc_cmd_lut #(
  parameter logic [127:0] VALID_MAP = {128{1'b1}},
  parameter logic [31:0] NV_MAP = 32'hffff0000
)(
  input wire logic [4:0] i_addr,
  input wire logic [1:0] i_op,
  input wire logic i_hv,
  output logic o_valid,
  output logic o_is_nv,
  output logic o_long,
  output logic o_wrong_level
);
  always_comb
  begin
    // lookup is indexed by address then operation code
    o_valid = VALID_MAP[{i_addr, i_op}];
    o_is_nv = NV_MAP[i_addr];
    o_long = (i_op == `DSC_OP_WRITE) || (i_op == `DSC_OP_READ);
    // read/write at elevated level, or enable/disable without it, is dropped silently
    o_wrong_level = o_long ? i_hv : !i_hv;
  end
endmodule

// ### dsc_spi_cmd_decoder.sv
// serial command decoder of a nonvolatile converter, link side and system side
// assumes: host drives i_sck/i_sdi/i_cs_n; i_sck runs only inside frames
`timescale 1ns/1ps
`include "dsc_map.svh"
module dsc_spi_cmd_decoder #(
  parameter logic [127:0] VALID_MAP = {128{1'b1}},
  parameter logic [31:0] NV_MAP = 32'hffff0000,
  parameter int DEPTH = 32
)(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_high_voltage_command_pin,
  input wire logic i_ee_busy,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_wr_strobe,
  output logic o_nv_wr_start,
  output logic o_cfg_en_strobe,
  output logic o_cfg_dis_strobe,
  output logic [4:0] o_cmd_addr,
  output logic [16:0] o_cmd_data,
  output logic o_command_error_flag
);
  // ==========================================
  // link domain: synchronised side inputs
  // select release clears all frame state at once, without waiting for a clock edge
  logic frame_rst;
  logic hv_s;
  logic busy_s;
  logic ce_s;

  assign frame_rst = i_sys_rst | i_cs_n;

  dsc_sync #(.W(3), .RST_VAL(3'h0)) u_link_sync (
    .i_clk(i_sck),
    .i_rst(i_sys_rst),
    .i_d({i_high_voltage_command_pin, i_ee_busy, i_ce}),
    .o_q({hv_s, busy_s, ce_s})
  );

  // ==========================================
  // link domain: frame state
  dsc_pkg::dsc_state_t state;
  dsc_pkg::dsc_state_t next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [15:0] shreg;
  logic [15:0] next_shreg;
  logic [4:0] cmd_addr;
  logic [4:0] next_cmd_addr;
  logic [1:0] cmd_op;
  logic [1:0] next_cmd_op;
  logic cmd_d8;
  logic next_cmd_d8;
  logic cmd_ign;
  logic next_cmd_ign;
  logic cmd_nv;
  logic next_cmd_nv;
  logic err;
  logic next_err;
  logic nv_done;
  logic next_nv_done;
  logic spoiled;
  logic next_spoiled;
  logic [15:0] rd_word;
  logic [15:0] next_rd_word;

  // persistent hand-over state survives select release so the system side can read it
  logic ev_tgl;
  logic next_ev_tgl;
  dsc_pkg::dsc_event_t ev_kind;
  dsc_pkg::dsc_event_t next_ev_kind;
  logic [4:0] ev_addr;
  logic [4:0] next_ev_addr;
  logic [16:0] ev_data;
  logic [16:0] next_ev_data;
  logic cancel_tgl;
  logic next_cancel_tgl;

  // mirror of the written locations, returned by reads
  logic [15:0] mem [DEPTH];
  logic mem_we;
  logic [15:0] mem_wd;

  logic lut_valid;
  logic lut_nv;
  logic lut_long;
  logic lut_wrong;
  logic [4:0] cand_addr;
  logic [1:0] cand_op;
  logic [15:0] word_in;
  logic next_sdo;

  assign cand_addr = shreg[5:1];
  assign cand_op = {shreg[0], i_sdi};
  assign word_in = {shreg[14:0], i_sdi};

  dsc_cmd_lut #(.VALID_MAP(VALID_MAP), .NV_MAP(NV_MAP)) u_lut (
    .i_addr((state == dsc_pkg::DSC_ST_CMD && cnt == `DSC_POS_OP_LAST) ? cand_addr : cmd_addr),
    .i_op((state == dsc_pkg::DSC_ST_CMD && cnt == `DSC_POS_OP_LAST) ? cand_op : cmd_op),
    .i_hv(hv_s),
    .o_valid(lut_valid),
    .o_is_nv(lut_nv),
    .o_long(lut_long),
    .o_wrong_level(lut_wrong)
  );

  always_comb
  begin
    next_state = state;
    next_cnt = cnt + `DSC_CNT_STEP;
    next_shreg = {shreg[14:0], i_sdi};
    next_cmd_addr = cmd_addr;
    next_cmd_op = cmd_op;
    next_cmd_d8 = cmd_d8;
    next_cmd_ign = cmd_ign;
    next_cmd_nv = cmd_nv;
    next_err = err;
    next_nv_done = nv_done;
    next_spoiled = spoiled;
    next_rd_word = rd_word;
    next_ev_tgl = ev_tgl;
    next_ev_kind = ev_kind;
    next_ev_addr = ev_addr;
    next_ev_data = ev_data;
    next_cancel_tgl = cancel_tgl;
    mem_we = 1'b0;
    mem_wd = word_in;
    // any clock after a nonvolatile write breaks its exact length
    if (nv_done && !spoiled)
    begin
      next_spoiled = 1'b1;
      next_cancel_tgl = !cancel_tgl;
    end
    case (state)
      dsc_pkg::DSC_ST_CMD:
      begin
        if (cnt == `DSC_POS_OP_LAST)
        begin
          next_cmd_addr = cand_addr;
          next_cmd_op = cand_op;
          next_cmd_nv = lut_nv;
          if (!lut_valid || nv_done)
          begin
            next_err = 1'b1;
          end
          next_cmd_ign = lut_wrong || (busy_s && lut_nv);
        end
        else if (cnt == `DSC_POS_CMD_LAST)
        begin
          next_cmd_d8 = i_sdi;
          if (lut_long)
          begin
            next_state = dsc_pkg::DSC_ST_DATA;
            next_rd_word = mem[cmd_addr];
          end
          else
          begin
            next_cnt = `DSC_CNT_ZERO;
            if (!err && !cmd_ign)
            begin
              next_ev_tgl = !ev_tgl;
              next_ev_kind = (cmd_op == `DSC_OP_ENABLE) ? dsc_pkg::DSC_EV_CFG_EN : dsc_pkg::DSC_EV_CFG_DIS;
              next_ev_addr = cmd_addr;
              next_ev_data = 17'h00000;
            end
          end
        end
      end
      dsc_pkg::DSC_ST_DATA:
      begin
        if (cnt == `DSC_POS_LONG_LAST)
        begin
          next_state = dsc_pkg::DSC_ST_CMD;
          next_cnt = `DSC_CNT_ZERO;
          if (!err && !cmd_ign && cmd_op == `DSC_OP_WRITE)
          begin
            mem_we = 1'b1;
            next_ev_tgl = !ev_tgl;
            next_ev_kind = cmd_nv ? dsc_pkg::DSC_EV_WR_NV : dsc_pkg::DSC_EV_WR_VOL;
            next_ev_addr = cmd_addr;
            next_ev_data = {cmd_d8, word_in};
            next_nv_done = cmd_nv;
          end
        end
      end
      default:
      begin
        next_state = dsc_pkg::DSC_ST_CMD;
      end
    endcase
  end

  always_ff @(posedge i_sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      state <= dsc_pkg::DSC_ST_CMD;
      cnt <= `DSC_CNT_ZERO;
      shreg <= `DSC_WORD_ZERO;
      cmd_addr <= 5'h00;
      cmd_op <= `DSC_OP_WRITE;
      cmd_d8 <= 1'b0;
      cmd_ign <= 1'b0;
      cmd_nv <= 1'b0;
      err <= 1'b0;
      nv_done <= 1'b0;
      spoiled <= 1'b0;
      rd_word <= `DSC_WORD_ZERO;
    end
    else if (ce_s)
    begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      cmd_addr <= next_cmd_addr;
      cmd_op <= next_cmd_op;
      cmd_d8 <= next_cmd_d8;
      cmd_ign <= next_cmd_ign;
      cmd_nv <= next_cmd_nv;
      err <= next_err;
      nv_done <= next_nv_done;
      spoiled <= next_spoiled;
      rd_word <= next_rd_word;
    end
  end

  always_ff @(posedge i_sck or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ev_tgl <= 1'b0;
      ev_kind <= dsc_pkg::DSC_EV_WR_VOL;
      ev_addr <= 5'h00;
      ev_data <= 17'h00000;
      cancel_tgl <= 1'b0;
    end
    else if (ce_s && !i_cs_n)
    begin
      ev_tgl <= next_ev_tgl;
      ev_kind <= next_ev_kind;
      ev_addr <= next_ev_addr;
      ev_data <= next_ev_data;
      cancel_tgl <= next_cancel_tgl;
    end
  end

  // mirror is not reset; unwritten locations read back as unknown
  always_ff @(posedge i_sck)
  begin
    if (ce_s && !i_cs_n && mem_we)
    begin
      mem[cmd_addr] <= mem_wd;
    end
  end

  // ==========================================
  // link domain: serial output on the falling edge
  always_comb
  begin
    if (err)
    begin
      next_sdo = 1'b0;
    end
    else if (state == dsc_pkg::DSC_ST_DATA && cmd_op == `DSC_OP_READ && !cmd_ign)
    begin
      next_sdo = rd_word[4'(`DSC_POS_LONG_LAST - cnt)];
    end
    else
    begin
      next_sdo = `DSC_SDO_IDLE;
    end
  end

  always_ff @(negedge i_sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      o_sdo <= `DSC_SDO_IDLE;
    end
    else if (ce_s)
    begin
      o_sdo <= next_sdo;
    end
  end

  // ==========================================
  // system domain: event reception
  logic ev_s;
  logic cancel_s;
  logic cs_n_s;
  logic err_s;
  logic ev_d;
  logic next_ev_d;
  logic cancel_d;
  logic next_cancel_d;
  logic cs_n_d;
  logic next_cs_n_d;
  logic nv_pend;
  logic next_nv_pend;
  logic [4:0] nv_addr;
  logic [4:0] next_nv_addr;
  logic [16:0] nv_data;
  logic [16:0] next_nv_data;
  logic next_wr_strobe;
  logic next_nv_wr_start;
  logic next_cfg_en;
  logic next_cfg_dis;
  logic [4:0] next_out_addr;
  logic [16:0] next_out_data;
  logic ev_edge;
  logic pend_eff;

  dsc_sync #(.W(4), .RST_VAL(4'h4)) u_sys_sync (
    .i_clk(i_clk),
    .i_rst(i_sys_rst),
    .i_d({ev_tgl, i_cs_n, cancel_tgl, err}),
    .o_q({ev_s, cs_n_s, cancel_s, err_s})
  );

  always_comb
  begin
    next_ev_d = ev_s;
    next_cancel_d = cancel_s;
    next_cs_n_d = cs_n_s;
    next_nv_pend = nv_pend;
    next_nv_addr = nv_addr;
    next_nv_data = nv_data;
    next_wr_strobe = 1'b0;
    next_nv_wr_start = 1'b0;
    next_cfg_en = 1'b0;
    next_cfg_dis = 1'b0;
    next_out_addr = o_cmd_addr;
    next_out_data = o_cmd_data;
    ev_edge = ev_s ^ ev_d;
    // payload is read only after its toggle has crossed, so it has been stable for two clocks
    if (ev_edge)
    begin
      // a nonvolatile write shows its fields only together with its start pulse
      if (ev_kind != dsc_pkg::DSC_EV_WR_NV)
      begin
        next_out_addr = ev_addr;
        next_out_data = ev_data;
      end
      case (ev_kind)
        dsc_pkg::DSC_EV_WR_VOL: next_wr_strobe = 1'b1;
        dsc_pkg::DSC_EV_WR_NV:
        begin
          next_nv_pend = 1'b1;
          next_nv_addr = ev_addr;
          next_nv_data = ev_data;
        end
        dsc_pkg::DSC_EV_CFG_EN: next_cfg_en = 1'b1;
        default: next_cfg_dis = 1'b1;
      endcase
    end
    pend_eff = next_nv_pend;
    if (cancel_s ^ cancel_d)
    begin
      pend_eff = 1'b0;
      next_nv_pend = 1'b0;
    end
    if (cs_n_s && !cs_n_d)
    begin
      next_nv_pend = 1'b0;
      if (pend_eff)
      begin
        next_nv_wr_start = 1'b1;
        next_out_addr = next_nv_addr;
        next_out_data = next_nv_data;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ev_d <= 1'b0;
      cancel_d <= 1'b0;
      cs_n_d <= 1'b1;
      nv_pend <= 1'b0;
      nv_addr <= 5'h00;
      nv_data <= 17'h00000;
      o_wr_strobe <= 1'b0;
      o_nv_wr_start <= 1'b0;
      o_cfg_en_strobe <= 1'b0;
      o_cfg_dis_strobe <= 1'b0;
      o_cmd_addr <= 5'h00;
      o_cmd_data <= 17'h00000;
      o_command_error_flag <= 1'b0;
      o_sdo_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      ev_d <= next_ev_d;
      cancel_d <= next_cancel_d;
      cs_n_d <= next_cs_n_d;
      nv_pend <= next_nv_pend;
      nv_addr <= next_nv_addr;
      nv_data <= next_nv_data;
      o_wr_strobe <= next_wr_strobe;
      o_nv_wr_start <= next_nv_wr_start;
      o_cfg_en_strobe <= next_cfg_en;
      o_cfg_dis_strobe <= next_cfg_dis;
      o_cmd_addr <= next_out_addr;
      o_cmd_data <= next_out_data;
      o_command_error_flag <= err_s;
      // enable follows the synchronised select, a few clocks behind the pin
      o_sdo_oe <= !cs_n_s;
    end
  end
endmodule

// ### dsc_checker.sv
// port checker for the serial command decoder
// assumes: bound to the top module; sees its ports only
`timescale 1ns/1ps
module dsc_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_high_voltage_command_pin,
  input wire logic o_sdo,
  input wire logic o_sdo_oe,
  input wire logic o_wr_strobe,
  input wire logic o_nv_wr_start,
  input wire logic o_cfg_en_strobe,
  input wire logic o_cfg_dis_strobe,
  input wire logic [4:0] o_cmd_addr,
  input wire logic [16:0] o_cmd_data,
  input wire logic o_command_error_flag
);
  // ==========
  // bit position in the frame
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic any_ev;
  // saturates so a long frame never wraps back into the command-byte window
  always_comb next_bit_cnt = (bit_cnt == 5'h1f) ? bit_cnt : bit_cnt + 5'h01;
  always_ff @(posedge i_sck or posedge i_cs_n or posedge i_sys_rst)
    if (i_cs_n || i_sys_rst)
      bit_cnt <= 5'h00;
    else
      bit_cnt <= next_bit_cnt;
  assign any_ev = o_wr_strobe | o_nv_wr_start | o_cfg_en_strobe | o_cfg_dis_strobe;
  // ==========
  // system side
  wr_pulse_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_wr_strobe |=> !o_wr_strobe) else $error("write strobe too long");
  nv_release_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_nv_wr_start |-> i_cs_n && $past(i_cs_n, 2)) else $error("nonvolatile start inside a frame");
  cfg_hv_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_cfg_en_strobe || o_cfg_dis_strobe) |-> i_high_voltage_command_pin && o_cmd_data == 17'h00000)
    else $error("configuration event without elevated pin");
  wr_normal_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_wr_strobe |-> !i_high_voltage_command_pin) else $error("write executed with elevated pin");
  ev_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $changed({o_cmd_addr, o_cmd_data}) |-> ##[0:1] any_ev) else $error("event fields moved alone");
  oe_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_cs_n [*3] |=> !o_sdo_oe) else $error("output enable after release");
  err_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_cs_n [*4] |=> !o_command_error_flag) else $error("error kept after release");
  idle_sdo_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_cs_n |-> o_sdo) else $error("serial output low while idle");
  // ==========
  // link side
  first_bits_a: assert property (@(posedge i_sck) disable iff (i_sys_rst || i_cs_n)
    bit_cnt < 5'h07 |-> o_sdo) else $error("command byte output not high");
  err_sdo_a: assert property (@(posedge i_sck) disable iff (i_sys_rst || i_cs_n)
    o_command_error_flag |-> !o_sdo) else $error("output high after error");
endmodule

// ### dsc_host_model.sv
// host controller model of the serial link, clock idles low
// assumes: tasks called by the bench, one at a time
`timescale 1ns/1ps
module dsc_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  logic [23:0] rx;
  int half = 3;
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
    rx = 24'h000000;
  end
  // ==========
  // frames and bits
  // select settles before the first clock edge
  task automatic sel();
    o_cs_n = 1'b0;
    #20;
  endtask
  task automatic desel();
    #20;
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
  endtask
  task automatic shift(input logic [23:0] tx, input int n);
    for (int k = n - 1; k >= 0; k--)
    begin
      o_sdi = tx[k];
      #(half);
      o_sck = 1'b1;
      rx = {rx[22:0], i_sdo};
      #(half);
      o_sck = 1'b0;
    end
  endtask
  task automatic c24(input logic [23:0] tx);
    shift(tx, 24);
  endtask
  task automatic c8(input logic [7:0] tx);
    shift({16'h0000, tx}, 8);
  endtask
  task automatic clk_n(input int n);
    shift(24'h5a5a5a, n);
  endtask
endmodule

// ### dsc_spi_cmd_decoder_test.sv
// self-checking bench for the serial command decoder
// assumes: host model drives the link; checker bound below
`timescale 1ns/1ps
module dsc_spi_cmd_decoder_test;
  logic i_clk, i_sys_rst, i_ce, hv, busy, sck, cs_n, sdi;
  logic sdo, sdo_oe, wr, nv, en, dis, err;
  logic [4:0] addr;
  logic [16:0] data;
  logic [4:0] ev_addr;
  logic [16:0] ev_data;
  int fails = 0;
  int n_checks = 0;
  int ev[4] = '{0, 0, 0, 0};
  int base[4];
  // ==========
  // device and host
  // read of location 31 made illegal
  dsc_spi_cmd_decoder #(.VALID_MAP({1'b0, {127{1'b1}}})) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_ce(i_ce), .i_sck(sck), .i_cs_n(cs_n), .i_sdi(sdi), .i_high_voltage_command_pin(hv), .i_ee_busy(busy),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_wr_strobe(wr), .o_nv_wr_start(nv), .o_cfg_en_strobe(en),
    .o_cfg_dis_strobe(dis), .o_cmd_addr(addr), .o_cmd_data(data), .o_command_error_flag(err));
  dsc_host_model host_u (.o_sck(sck), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    if ({wr, nv, en, dis} !== 4'h0)
    begin
      ev_addr <= addr;
      ev_data <= data;
    end
    ev[0] <= ev[0] + int'(wr === 1'b1);
    ev[1] <= ev[1] + int'(nv === 1'b1);
    ev[2] <= ev[2] + int'(en === 1'b1);
    ev[3] <= ev[3] + int'(dis === 1'b1);
  end
  // ==========
  // helpers
  task automatic cmp_v(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // two bits a kind: write, nonvolatile start, enable, disable
  task automatic expect_ev(input logic [7:0] e);
    for (int k = 0; k < 4; k++)
      cmp_v(24'(ev[k] - base[k]), {22'h0, e[7-2*k -: 2]});
  endtask
  task automatic open_f();
    base = ev;
    host_u.sel();
  endtask
  task automatic close_f();
    host_u.desel();
    gap(10);
  endtask
  task automatic conclude();
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic s_partial();
    open_f();
    host_u.clk_n(5);
    close_f();
    expect_ev(8'h00);
  endtask
  task automatic s_write();
    open_f();
    host_u.c24({5'h03, 2'h0, 17'h1a5c3});
    cmp_v(host_u.rx, 24'hffffff);
    gap(8);
    expect_ev(8'h40);
    cmp_v({2'h0, ev_addr, ev_data}, {2'h0, 5'h03, 17'h1a5c3});
    cmp_v({23'h0, sdo_oe}, 24'h000001);
    close_f();
  endtask
  task automatic s_mixed();
    open_f();
    host_u.c24({5'h03, 2'h3, 17'h10000});
    cmp_v(host_u.rx, 24'hffa5c3);
    gap(6);
    host_u.c24({5'h05, 2'h0, 17'h00012});
    gap(6);
    host_u.c24({5'h14, 2'h0, 17'h1beef});
    gap(8);
    expect_ev(8'h40);
    cmp_v({2'h0, ev_addr, ev_data}, {2'h0, 5'h05, 17'h00012});
    close_f();
    expect_ev(8'h50);
    cmp_v({2'h0, ev_addr, ev_data}, {2'h0, 5'h14, 17'h1beef});
  endtask
  task automatic s_nv_err();
    open_f();
    host_u.c24({5'h15, 2'h0, 17'h00001});
    gap(6);
    host_u.c24({5'h16, 2'h0, 17'h00002});
    cmp_v(host_u.rx, 24'hfe0000);
    gap(6);
    cmp_v({23'h0, err}, 24'h000001);
    host_u.c24({5'h05, 2'h0, 17'h00003});
    cmp_v(host_u.rx, 24'h000000);
    close_f();
    expect_ev(8'h00);
    cmp_v({23'h0, err}, 24'h000000);
  endtask
  task automatic s_illegal();
    open_f();
    host_u.c24({5'h1f, 2'h3, 17'h00000});
    cmp_v(host_u.rx, 24'hfe0000);
    gap(6);
    host_u.c24({5'h04, 2'h0, 17'h00004});
    cmp_v(host_u.rx, 24'h000000);
    close_f();
    expect_ev(8'h00);
  endtask
  task automatic s_hv();
    hv = 1'b1;
    open_f();
    host_u.c8({5'h08, 2'h2, 1'b0});
    cmp_v({16'h0, host_u.rx[7:0]}, 24'h0000ff);
    gap(6);
    host_u.c8({5'h09, 2'h1, 1'b0});
    gap(6);
    host_u.c24({5'h05, 2'h0, 17'h00009});
    gap(6);
    host_u.c8({5'h0a, 2'h2, 1'b0});
    gap(8);
    expect_ev(8'h09);
    cmp_v({2'h0, ev_addr, ev_data}, {2'h0, 5'h0a, 17'h00000});
    cmp_v({23'h0, err}, 24'h000000);
    close_f();
    hv = 1'b0;
    gap(2);
    open_f();
    host_u.c8({5'h08, 2'h2, 1'b0});
    close_f();
    expect_ev(8'h00);
  endtask
  task automatic s_busy();
    busy = 1'b1;
    open_f();
    host_u.c24({5'h16, 2'h3, 17'h00000});
    cmp_v(host_u.rx, 24'hffffff);
    host_u.c24({5'h16, 2'h0, 17'h00005});
    cmp_v(host_u.rx, 24'hffffff);
    gap(6);
    host_u.c24({5'h07, 2'h0, 17'h00006});
    close_f();
    busy = 1'b0;
    expect_ev(8'h40);
    cmp_v({2'h0, ev_addr, ev_data}, {2'h0, 5'h07, 17'h00006});
  endtask
  // link state stops two clocks after the enable drops, so the write never completes
  task automatic s_freeze();
    i_ce = 1'b0;
    open_f();
    host_u.c24({5'h02, 2'h0, 17'h00007});
    host_u.desel();
    gap(1);
    i_ce = 1'b1;
    gap(10);
    expect_ev(8'h00);
    cmp_v({23'h0, sdo_oe}, 24'h000000);
    // first clocks of the next frame only refill the enable synchroniser
    open_f();
    host_u.clk_n(2);
    close_f();
    expect_ev(8'h00);
  endtask
  // ==========
  // main sequence
  initial
  begin
    i_ce = 1'b1;
    hv = 1'b0;
    busy = 1'b0;
    i_sys_rst = 1'b1;
    gap(5);
    cmp_v({sdo, sdo_oe, err, wr, nv, en, dis, addr, 12'h000}, 24'h800000);
    cmp_v({7'h00, data}, 24'h000000);
    gap(5);
    i_sys_rst = 1'b0;
    gap(2);
    s_partial();
    s_write();
    s_mixed();
    s_nv_err();
    s_illegal();
    s_hv();
    s_busy();
    s_freeze();
    conclude();
  end
  initial
  begin
    #1000000;
    fails++;
    conclude();
  end
endmodule
bind dsc_spi_cmd_decoder dsc_checker chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sck(i_sck),
  .i_cs_n(i_cs_n), .i_high_voltage_command_pin(i_high_voltage_command_pin), .o_sdo(o_sdo),
  .o_sdo_oe(o_sdo_oe), .o_wr_strobe(o_wr_strobe), .o_nv_wr_start(o_nv_wr_start),
  .o_cfg_en_strobe(o_cfg_en_strobe), .o_cfg_dis_strobe(o_cfg_dis_strobe), .o_cmd_addr(o_cmd_addr),
  .o_cmd_data(o_cmd_data), .o_command_error_flag(o_command_error_flag));
